// ### core/ddp_defines.svh
`ifndef DDP_DEFINES_SVH
`define DDP_DEFINES_SVH
`define DDP_SFR_BASE 8'h80
`define DDP_ADDR_STACK 8'h81
`define DDP_ADDR_PTR0_LO 8'h82
`define DDP_ADDR_PTR0_HI 8'h83
`define DDP_ADDR_PTR1_LO 8'h84
`define DDP_ADDR_PTR1_HI 8'h85
`define DDP_ADDR_SEL 8'h86
`define DDP_ADDR_WAIT 8'h92
`define DDP_SEL_BIT 0
`define DDP_TOGGLE_BIT 5
`define DDP_STEP0_BIT 6
`define DDP_STEP1_BIT 7
`define DDP_STACK_MASK 8'h7F
`define DDP_SEL_MASK 8'hE1
`define DDP_WAIT_MASK 8'h07
`define DDP_STACK_RESET 8'h07
`define DDP_PTR_RESET 16'h0000
`define DDP_SEL_RESET 8'h00
`define DDP_WAIT_RESET 8'h04
`endif

// ### core/ddp_pkg.sv
package ddp_pkg;
    // Pointer operation requested by the instruction decoder
    typedef enum logic [1:0] {
        DDP_OP_NONE,
        DDP_OP_STEP,
        DDP_OP_USE
    } ddp_op_type;
endpackage : ddp_pkg

// ### core/ddp_wait_counter.sv
`timescale 1ns/1ps
`include "ddp_defines.svh"
// Program memory access timer: a fetch start is answered after 1..8 clocks
module ddp_wait_counter (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [2:0] wait_sel,
    input wire logic fetch_start,
    output logic fetch_busy,
    output logic fetch_done
);
    logic [2:0] cnt_q;
    logic [2:0] cnt_d;
    logic busy_q;
    logic busy_d;
    logic done_q;
    logic done_d;
    wire logic last = (cnt_q == 3'h0);

    // A start while busy is ignored so one access never overlaps the next
    always_comb begin
        cnt_d = cnt_q;
        busy_d = busy_q;
        done_d = 1'b0;
        if (busy_q) begin
            if (last) begin
                busy_d = 1'b0;
                done_d = 1'b1;
            end else begin
                cnt_d = cnt_q - 3'h1;
            end
        end else if (fetch_start) begin
            if (wait_sel == 3'h0) begin
                done_d = 1'b1;
            end else begin
                busy_d = 1'b1;
                cnt_d = wait_sel - 3'h1;
            end
        end
    end

    // Counter state
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 3'h0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    assign fetch_busy = busy_q;
    assign fetch_done = done_q;
endmodule : ddp_wait_counter

// ### core/ddp_sfr_bank.sv
`timescale 1ns/1ps
`include "ddp_defines.svh"
// Dual data pointer, stack pointer and wait state special function registers
module ddp_sfr_bank (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    output logic sfr_hit,
    input wire ddp_pkg::ddp_op_type ptr_op,
    input wire logic fetch_start,
    output logic fetch_busy,
    output logic fetch_done,
    output logic [15:0] active_ptr,
    output logic [6:0] stack_ptr,
    output logic [2:0] wait_cycles
);
    logic [15:0] ptr0_q;
    logic [15:0] ptr0_d;
    logic [15:0] ptr1_q;
    logic [15:0] ptr1_d;
    logic [7:0] sel_q;
    logic [7:0] sel_d;
    logic [7:0] stack_q;
    logic [7:0] stack_d;
    logic [7:0] wt_q;
    logic [7:0] wt_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic hit_q;
    logic [15:0] act_q;

    // Address decode: only direct SFR addresses 0x80..0xFF can hit
    wire logic in_sfr = sfr_addr[7];
    wire logic hit_stack = in_sfr && (sfr_addr == `DDP_ADDR_STACK);
    wire logic hit_p0l = in_sfr && (sfr_addr == `DDP_ADDR_PTR0_LO);
    wire logic hit_p0h = in_sfr && (sfr_addr == `DDP_ADDR_PTR0_HI);
    wire logic hit_p1l = in_sfr && (sfr_addr == `DDP_ADDR_PTR1_LO);
    wire logic hit_p1h = in_sfr && (sfr_addr == `DDP_ADDR_PTR1_HI);
    wire logic hit_sel = in_sfr && (sfr_addr == `DDP_ADDR_SEL);
    wire logic hit_wt = in_sfr && (sfr_addr == `DDP_ADDR_WAIT);
    wire logic any_hit = hit_stack | hit_p0l | hit_p0h | hit_p1l | hit_p1h | hit_sel | hit_wt;

    // Select field views
    wire logic use_second = sel_q[`DDP_SEL_BIT];
    wire logic toggle_en = sel_q[`DDP_TOGGLE_BIT];
    wire logic first_pointer_step_dir = sel_q[`DDP_STEP0_BIT];
    wire logic second_pointer_step_dir = sel_q[`DDP_STEP1_BIT];
    wire logic do_step = (ptr_op == ddp_pkg::DDP_OP_STEP);
    wire logic do_use = (ptr_op != ddp_pkg::DDP_OP_NONE);

    // Stepped value of each pointer, wrapping over all 16 bits
    wire logic [15:0] ptr0_step = first_pointer_step_dir ?
        ptr0_q - 16'h0001 : ptr0_q + 16'h0001;
    wire logic [15:0] ptr1_step = second_pointer_step_dir ?
        ptr1_q - 16'h0001 : ptr1_q + 16'h0001;

    // Read mux, reserved bits come back as zero
    assign rdata_d = hit_stack ? (stack_q & `DDP_STACK_MASK) :
                     hit_p0l ? ptr0_q[7:0] :
                     hit_p0h ? ptr0_q[15:8] :
                     hit_p1l ? ptr1_q[7:0] :
                     hit_p1h ? ptr1_q[15:8] :
                     hit_sel ? (sel_q & `DDP_SEL_MASK) :
                     hit_wt ? (wt_q & `DDP_WAIT_MASK) : 8'h00;

    // Next state; a software write in the same cycle as an instruction step wins,
    // since the write is the later program-order effect
    always_comb begin
        ptr0_d = ptr0_q;
        ptr1_d = ptr1_q;
        sel_d = sel_q;
        if (do_step && !use_second) begin
            ptr0_d = ptr0_step;
        end
        if (do_step && use_second) begin
            ptr1_d = ptr1_step;
        end
        if (do_use && toggle_en) begin
            sel_d[`DDP_SEL_BIT] = ~sel_q[`DDP_SEL_BIT];
        end
        if (sfr_wr && hit_p0l) begin
            ptr0_d[7:0] = sfr_wdata;
        end
        if (sfr_wr && hit_p0h) begin
            ptr0_d[15:8] = sfr_wdata;
        end
        if (sfr_wr && hit_p1l) begin
            ptr1_d[7:0] = sfr_wdata;
        end
        if (sfr_wr && hit_p1h) begin
            ptr1_d[15:8] = sfr_wdata;
        end
        if (sfr_wr && hit_sel) begin
            sel_d = sfr_wdata & `DDP_SEL_MASK;
        end
    end

    // Masked stores keep reserved bits at zero whatever is written
    assign stack_d = (sfr_wr && hit_stack) ? (sfr_wdata & `DDP_STACK_MASK) : stack_q;
    assign wt_d = (sfr_wr && hit_wt) ? (sfr_wdata & `DDP_WAIT_MASK) : wt_q;

    // Register storage
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ptr0_q <= `DDP_PTR_RESET;
            ptr1_q <= `DDP_PTR_RESET;
            sel_q <= `DDP_SEL_RESET;
            stack_q <= `DDP_STACK_RESET;
            wt_q <= `DDP_WAIT_RESET;
        end else begin
            ptr0_q <= ptr0_d;
            ptr1_q <= ptr1_d;
            sel_q <= sel_d;
            stack_q <= stack_d;
            wt_q <= wt_d;
        end
    end

    // Registered read data and pointer view for the outputs
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
            hit_q <= 1'b0;
            act_q <= `DDP_PTR_RESET;
        end else begin
            rdata_q <= sfr_rd ? rdata_d : 8'h00;
            hit_q <= (sfr_rd | sfr_wr) & any_hit;
            act_q <= sel_d[`DDP_SEL_BIT] ? ptr1_d : ptr0_d;
        end
    end

    assign sfr_rdata = rdata_q;
    assign sfr_hit = hit_q;
    assign active_ptr = act_q;
    assign stack_ptr = stack_q[6:0];
    assign wait_cycles = wt_q[2:0];

    // Program memory access timer
    ddp_wait_counter u_wait (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .wait_sel(wt_q[2:0]),
        .fetch_start(fetch_start),
        .fetch_busy(fetch_busy),
        .fetch_done(fetch_done)
    );

    // Select bit: toggled by pointer instructions only while enabled, writes stored masked
    a_sel_toggle: assert property (@(posedge mclk) disable iff (sys_rst)
        (do_use && toggle_en && !(sfr_wr && hit_sel)) |=> (sel_q[0] != $past(sel_q[0])))
        else $error("select bit did not toggle");
    a_sel_hold: assert property (@(posedge mclk) disable iff (sys_rst)
        (!toggle_en && !(sfr_wr && hit_sel)) |=> (sel_q[0] == $past(sel_q[0])))
        else $error("select bit changed without toggle");
    a_sel_write: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_wr && hit_sel) |=> (sel_q == ($past(sfr_wdata) & `DDP_SEL_MASK)))
        else $error("select write not stored masked");
    a_active_view: assert property (@(posedge mclk) disable iff (sys_rst)
        active_ptr == (sel_q[`DDP_SEL_BIT] ? ptr1_q : ptr0_q))
        else $error("active pointer view wrong");

    // Stepping moves only the selected pointer, by one, in the direction of its field
    a_ptr0_step: assert property (@(posedge mclk) disable iff (sys_rst)
        (do_step && !use_second && !(sfr_wr && (hit_p0l || hit_p0h)))
        |=> (ptr0_q == ($past(sel_q[6]) ? $past(ptr0_q) - 16'h0001
            : $past(ptr0_q) + 16'h0001)))
        else $error("first pointer step wrong");
    a_ptr1_step: assert property (@(posedge mclk) disable iff (sys_rst)
        (do_step && use_second && !(sfr_wr && (hit_p1l || hit_p1h)))
        |=> (ptr1_q == ($past(sel_q[7]) ? $past(ptr1_q) - 16'h0001
            : $past(ptr1_q) + 16'h0001)))
        else $error("second pointer step wrong");
    a_idle_ptr: assert property (@(posedge mclk) disable iff (sys_rst)
        (do_step && !use_second && !sfr_wr) |=> $stable(ptr1_q))
        else $error("idle pointer moved");
    a_idle_first: assert property (@(posedge mclk) disable iff (sys_rst)
        (do_step && use_second && !sfr_wr) |=> $stable(ptr0_q))
        else $error("idle first pointer moved");

    // Byte writes land whole; reserved bits never hold a one, whatever was written
    a_ptr0_low: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_wr && hit_p0l) |=> (ptr0_q[7:0] == $past(sfr_wdata)))
        else $error("first pointer low write lost");
    a_ptr0_high: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_wr && hit_p0h) |=> (ptr0_q[15:8] == $past(sfr_wdata)))
        else $error("first pointer high write lost");
    a_ptr1_low: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_wr && hit_p1l) |=> (ptr1_q[7:0] == $past(sfr_wdata)))
        else $error("second pointer low write lost");
    a_ptr1_high: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_wr && hit_p1h) |=> (ptr1_q[15:8] == $past(sfr_wdata)))
        else $error("second pointer high write lost");
    a_stack_write: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_wr && hit_stack) |=> (stack_ptr == $past(sfr_wdata[6:0])))
        else $error("stack pointer write lost");
    a_wait_write: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_wr && hit_wt) |=> (wait_cycles == $past(sfr_wdata[2:0])))
        else $error("wait field write lost");
    a_rsv_zero: assert property (@(posedge mclk) disable iff (sys_rst)
        (sel_q[4:1] == 4'h0) && (stack_q[7] == 1'b0) && (wt_q[7:3] == 5'h00))
        else $error("reserved bit set");

    // Read side: mapped places answer with a hit, anything else reads as zero
    a_low_miss: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_rd && !sfr_addr[7]) |=> (sfr_rdata == 8'h00) && !sfr_hit)
        else $error("low address answered");
    a_miss_quiet: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_rd && !any_hit) |=> (sfr_rdata == 8'h00) && !sfr_hit)
        else $error("unmapped address answered");
    a_read_hit: assert property (@(posedge mclk) disable iff (sys_rst)
        (sfr_rd && any_hit) |=> sfr_hit)
        else $error("mapped read gave no hit");

    // Access timer: a taken start ends after the wait code plus one clocks
    a_wait_len: assert property (@(posedge mclk) disable iff (sys_rst)
        (fetch_start && !fetch_busy && (wt_q[2:0] == 3'h4)) |-> ##5 fetch_done)
        else $error("five clock access wrong");
    a_wait_fast: assert property (@(posedge mclk) disable iff (sys_rst)
        (fetch_start && !fetch_busy && (wt_q[2:0] == 3'h0)) |=> fetch_done)
        else $error("one clock access wrong");
    a_wait_long: assert property (@(posedge mclk) disable iff (sys_rst)
        (fetch_start && !fetch_busy && (wt_q[2:0] == 3'h7)) |-> ##8 fetch_done)
        else $error("eight clock access wrong");
    a_busy_start: assert property (@(posedge mclk) disable iff (sys_rst)
        (fetch_start && !fetch_busy && (wt_q[2:0] != 3'h0)) |=> (fetch_busy && !fetch_done))
        else $error("access did not go busy");
endmodule : ddp_sfr_bank

// ### dv/test_dual_data_pointer_sfrs.sv
`timescale 1ns/1ps
module test_dual_data_pointer_sfrs;
    logic mclk, sys_rst, sfr_wr, sfr_rd, fetch_start, sfr_hit, fetch_busy, fetch_done;
    logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
    logic [15:0] active_ptr, v, e;
    logic [6:0] stack_ptr;
    logic [2:0] wait_cycles;
    logic [31:0] rs = 32'h60F79A0B;
    ddp_pkg::ddp_op_type ptr_op;
    int errors = 0;
    int compares = 0;
    int n;
    // Mapped places first, then one unused SFR slot and one address below the SFR space
    logic [7:0] addrs [9] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h86, 8'h92, 8'h87, 8'h05};
    logic [7:0] rstv [9] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00};

    ddp_sfr_bank uut (.mclk, .sys_rst, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
        .sfr_hit, .ptr_op, .fetch_start, .fetch_busy, .fetch_done, .active_ptr, .stack_ptr,
        .wait_cycles);

    // Bits that keep written data; reserved bits always read back zero
    function automatic logic [7:0] mask_of(input logic [7:0] a);
        case (a)
            8'h81: mask_of = 8'h7F;
            8'h86: mask_of = 8'hE1;
            8'h92: mask_of = 8'h07;
            8'h82, 8'h83, 8'h84, 8'h85: mask_of = 8'hFF;
            default: mask_of = 8'h00;
        endcase
    endfunction : mask_of

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // Bus tasks start and end on a rising edge; a write leaves the bus free for a read next
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge mclk);
        sfr_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge mclk);
        sfr_rd <= 1'b0;
        #1;
        chk("read data", {8'h00, exp}, {8'h00, sfr_rdata});
        chk("hit", {15'h0000, mask_of(a) != 8'h00}, {15'h0000, sfr_hit});
        @(posedge mclk);
    endtask : rd

    task automatic op(input ddp_pkg::ddp_op_type o);
        ptr_op <= o;
        @(posedge mclk);
        ptr_op <= ddp_pkg::DDP_OP_NONE;
        repeat (2) @(posedge mclk);
    endtask : op

    task automatic tally_and_finish;
        $display("errors=%0d compares=%0d", errors, compares);
        if (errors == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // The whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        tally_and_finish();
    end

    initial begin
        int m, s, k, w;
        logic dec;
        sys_rst = 1'b1;
        sfr_wr = 1'b0;
        sfr_rd = 1'b0;
        sfr_addr = 8'h00;
        sfr_wdata = 8'h00;
        fetch_start = 1'b0;
        ptr_op = ddp_pkg::DDP_OP_NONE;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        chk("wait field", 16'h0004, {13'h0000, wait_cycles});
        chk("stack", 16'h0007, {9'h000, stack_ptr});
        for (n = 0; n < 9; n++) rd(addrs[n], rstv[n]);
        // Random data, read back at once to catch a lost or late write
        for (n = 0; n < 9; n++) begin
            rs = lfsr(rs);
            wr(addrs[n], rs[7:0]);
            rd(addrs[n], rs[7:0] & mask_of(addrs[n]));
            if (n == 0) begin
                chk("stack", {9'h000, rs[6:0]}, {9'h000, stack_ptr});
            end
        end
        // Every step code on both pointers, wrap values first, then random ones
        for (k = 0; k < 2; k++)
            for (m = 0; m < 4; m++)
                for (s = 0; s < 2; s++) begin
                    dec = s ? m[1] : m[0];
                    rs = lfsr(rs);
                    v = k ? rs[15:0] : (dec ? 16'h0000 : 16'hFFFF);
                    wr(8'h82 + 8'(2 * s), v[7:0]);
                    @(posedge mclk);
                    wr(8'h83 + 8'(2 * s), v[15:8]);
                    @(posedge mclk);
                    wr(8'h86, {m[1:0], 5'b00000, s[0]});
                    op(ddp_pkg::DDP_OP_STEP);
                    #1;
                    e = dec ? v - 16'h0001 : v + 16'h0001;
                    chk("active pointer", e, active_ptr);
                    @(posedge mclk);
                    rd(8'h83 + 8'(2 * s), e[15:8]);
                end
        // Toggle on use only while enabled
        wr(8'h86, 8'h20);
        op(ddp_pkg::DDP_OP_USE);
        rd(8'h86, 8'h21);
        op(ddp_pkg::DDP_OP_STEP);
        rd(8'h86, 8'h20);
        wr(8'h86, 8'h00);
        op(ddp_pkg::DDP_OP_USE);
        rd(8'h86, 8'h00);
        // Access time for every wait code
        for (w = 0; w < 8; w++) begin
            wr(8'h92, 8'(w));
            @(posedge mclk);
            fetch_start <= 1'b1;
            @(posedge mclk);
            fetch_start <= 1'b0;
            // The start was taken at this edge; count clocks until the done pulse shows
            n = 1;
            #1;
            chk("wait field", 16'(w), {13'h0000, wait_cycles});
            while (fetch_done !== 1'b1 && n < 12) begin
                chk("fetch busy", 16'h0001, {15'h0000, fetch_busy});
                @(posedge mclk);
                #1;
                n++;
            end
            chk("fetch clocks", 16'(w + 1), 16'(n));
            chk("fetch busy", 16'h0000, {15'h0000, fetch_busy});
            @(posedge mclk);
        end
        tally_and_finish();
    end
endmodule : test_dual_data_pointer_sfrs
